// ===== spi_rom_boot_select_test.sv
// Testbench: strap, signature boot and flash reads through the register bus
module spi_rom_boot_select_test;
  timeunit 1ns;
  timeprecision 1ps;
  import srbs_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [15:0] awaddr = 16'h0000;
  logic awvalid = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic [15:0] araddr = 16'h0000;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic strap = 1'h1;
  logic present = 1'h1;
  logic sig_ok = 1'h1;
  logic awready, wready, bvalid, arready, rvalid, cs_n, sclk, io0_o, io0_oe, pd_en;
  logic boot_ext, boot_rdy, m_io1, m_io0, m_oe;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [23:0] a;
  int n;
  int errors = 0;
  int checked = 0;
  wire io0_pin = io0_oe ? io0_o : (m_oe ? m_io0 : strap);

  always #12.5 aclk = ~aclk;

  srbs_boot_select uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .flash_cs_n(cs_n), .flash_sclk(sclk),
    .flash_io0_i(io0_pin), .flash_io0_o(io0_o), .flash_io0_oe(io0_oe),
    .flash_io0_pd_en(pd_en), .flash_io1_i(m_io1), .boot_from_ext(boot_ext),
    .boot_ready(boot_rdy));

  srbs_flash_model fm (.cs_n(cs_n), .sclk(sclk), .io0(io0_pin), .present(present),
    .sig_ok(sig_ok), .io1_o(m_io1), .io0_o(m_io0), .io0_oe(m_oe));

  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic tmo();
    errors++;
    $display("Error timeout");
    print_verdict();
  endtask : tmo

  task automatic chk_word(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask : chk_word

  task automatic chk_bit(input string s, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %b seen %b", s, e, g);
    end
  endtask : chk_bit

  function automatic logic [31:0] wexp(input logic [23:0] x);
    return {fm.byte_at(x), fm.byte_at(x + 24'h1), fm.byte_at(x + 24'h2), fm.byte_at(x + 24'h3)};
  endfunction : wexp

  // ----------------------------------------------------------------
  // Register bus master
  // ----------------------------------------------------------------
  task automatic wr(input logic [15:0] ad, input logic [31:0] dt, input logic [1:0] er);
    int k;
    logic aw;
    logic w;
    aw = 1'h1;
    w = 1'h1;
    k = 0;
    @(posedge aclk);
    awaddr <= ad;
    wdata <= dt;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (k < 300) begin
      @(posedge aclk);
      k++;
      if (!aw && !w && bvalid === 1'h1) break;
      if (aw && awready === 1'h1) begin
        aw = 1'h0;
        awvalid <= 1'h0;
      end
      if (w && wready === 1'h1) begin
        w = 1'h0;
        wvalid <= 1'h0;
      end
    end
    if (k >= 300) tmo();
    bready <= 1'h0;
    chk_word("bresp", {30'h0, er}, {30'h0, bresp});
  endtask : wr

  task automatic rd(input logic [15:0] ad, output logic [31:0] dt, output logic [1:0] rr);
    int k;
    logic ar;
    ar = 1'h1;
    k = 0;
    @(posedge aclk);
    araddr <= ad;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (k < 300) begin
      @(posedge aclk);
      k++;
      if (!ar && rvalid === 1'h1) break;
      if (ar && arready === 1'h1) begin
        ar = 1'h0;
        arvalid <= 1'h0;
      end
    end
    if (k >= 300) tmo();
    dt = rdata;
    rr = rresp;
    rready <= 1'h0;
  endtask : rd

  task automatic boot(input logic s, input logic p, input logic g);
    int k;
    k = 0;
    @(posedge aclk);
    aresetn <= 1'h0;
    strap <= s;
    present <= p;
    sig_ok <= g;
    repeat (4) @(posedge aclk);
    chk_bit("pull-down in reset", 1'h1, pd_en);
    chk_bit("drive in reset", 1'h0, io0_oe);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    chk_bit("pull-down after", 1'h0, pd_en);
    while (boot_rdy !== 1'h1 && k < 20000) begin
      @(posedge aclk);
      k++;
    end
    if (k >= 20000) tmo();
    rd(CTRL_OFS, d, r);
    chk_word("control", {31'h0, g & p} << 3 | {31'h0, s} << 1, d & 32'h1A);
  endtask : boot

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    boot(1'h1, 1'h1, 1'h1);
    chk_bit("external boot", 1'h1, boot_ext);
    chk_word("boot address", {8'h0, BOOT_ADDR}, {8'h0, fm.last_addr});
    rd(RDATA_OFS, d, r);
    chk_word("boot word", wexp(BOOT_ADDR), d);
    for (int i = 0; i < 4; i++) begin
      a = {16'h2C5A, 6'h0, i[1:0]};
      wr(CTRL_OFS, {26'h0, 1'h1, 2'h0, i[1], 1'h0, i[0]}, RESP_OKAY);
      wr(RADDR_OFS, {8'h0, a}, RESP_OKAY);
      n = 0;
      do begin
        rd(CTRL_OFS, d, r);
        n++;
      end while (d[CTL_DONE_BIT] !== 1'h1 && n < 1000);
      if (n >= 1000) tmo();
      rd(RDATA_OFS, d, r);
      chk_word("flash word", wexp(a), d);
      chk_word("command", {24'h0, i[0] ? CMD_DREAD : CMD_READ}, {24'h0, fm.last_cmd});
      chk_bit("idle clock", i[1], sclk);
    end
    chk_bit("boot held", 1'h1, boot_ext);
    wr(16'h2500, 32'h1, RESP_SLVERR);
    wr(RDATA_OFS, 32'h1, RESP_OKAY);
    rd(16'h2500, d, r);
    chk_word("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    chk_word("unmapped data", 32'h0, d);
    boot(1'h0, 1'h1, 1'h0);
    chk_bit("internal boot", 1'h0, boot_ext);
    chk_word("signature cmd", {CMD_READ, SIG_ADDR}, {fm.last_cmd, fm.last_addr});
    boot(1'h1, 1'h0, 1'h0);
    chk_bit("no flash", 1'h0, boot_ext);
    print_verdict();
  end
endmodule : spi_rom_boot_select_test

// ===== srbs_boot_select.sv
// Boot source selector: speed strap, signature check, flash fetch, AXI4-Lite registers
module srbs_boot_select (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic flash_cs_n,
  output logic flash_sclk,
  input wire logic flash_io0_i,
  output logic flash_io0_o,
  output logic flash_io0_oe,
  output logic flash_io0_pd_en,
  input wire logic flash_io1_i,
  output logic boot_from_ext,
  output logic boot_ready
);
  import srbs_pkg::*;

  srbs_boot_st_t state_ff;
  logic io0_s1_ff;
  logic io0_s2_ff;
  logic io1_s1_ff;
  logic io1_s2_ff;
  logic speed_ff;
  logic strap_done_ff;
  logic boot_ext_ff;
  logic dual_en_ff;
  logic mode3_ff;
  logic done_flag_ff;
  logic sw_go_ff;
  logic [23:0] raddr_ff;
  logic [31:0] word_ff;
  logic aw_have_ff;
  logic w_have_ff;
  logic bvalid_ff;
  logic rvalid_ff;
  logic [15:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic [1:0] bresp_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;
  logic [31:0] rd_mux;
  logic [7:0] ctl_rd;
  logic wr_fire;
  logic wr_ctl;
  logic wr_raddr;
  logic sw_take;
  logic fetch_done;
  logic sig_match;
  logic xfer_start;
  logic xfer_busy;
  logic xfer_done;
  logic [31:0] xfer_rdata;
  srbs_xfer_req_t xfer_req;
  srbs_flash_out_t xfer_pins;

  function automatic logic reg_hit(input logic [15:0] addr);
    reg_hit = (addr == CTRL_OFS) || (addr == RADDR_OFS) || (addr == RDATA_OFS);
  endfunction : reg_hit

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    io0_s1_ff <= flash_io0_i;
    io0_s2_ff <= io0_s1_ff;
    io1_s1_ff <= flash_io1_i;
    io1_s2_ff <= io1_s1_ff;
  end

  // ----------------------------------------------------------------
  // Speed strap
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      speed_ff <= CTRL_RST[CTL_SPEED_BIT];
      strap_done_ff <= 1'h0;
    end else if (state_ff == ST_STRAP) begin
      speed_ff <= io0_s2_ff;
      strap_done_ff <= 1'h1;
    end
  end

  // ----------------------------------------------------------------
  // Boot sequence
  // ----------------------------------------------------------------
  assign sig_match = xfer_done && (xfer_rdata == SIG_WORD);
  assign sw_take = (state_ff == ST_RUN) && sw_go_ff && !xfer_busy;
  assign xfer_start = (state_ff == ST_SIG) || (state_ff == ST_FETCH) || sw_take;
  assign fetch_done = xfer_done && ((state_ff == ST_FWAIT) || (state_ff == ST_RUN));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= ST_STRAP;
    end else begin
      unique case (state_ff)
        ST_STRAP: state_ff <= ST_SIG;
        ST_SIG: state_ff <= ST_SIG_WAIT;
        ST_SIG_WAIT: begin
          if (sig_match) begin
            state_ff <= ST_FETCH;
          end else if (xfer_done) begin
            state_ff <= ST_RUN;
          end
        end
        ST_FETCH: state_ff <= ST_FWAIT;
        ST_FWAIT: begin
          if (xfer_done) begin
            state_ff <= ST_RUN;
          end
        end
        ST_RUN: state_ff <= ST_RUN;
      endcase
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot_ext_ff <= 1'h0;
    end else if (state_ff == ST_SIG_WAIT && sig_match) begin
      boot_ext_ff <= 1'h1;
    end
  end
  always_comb begin
    xfer_req.fast = speed_ff;
    xfer_req.mode3 = mode3_ff;
    xfer_req.dual = dual_en_ff;
    xfer_req.addr = raddr_ff;
    if (state_ff == ST_SIG) begin
      xfer_req.addr = SIG_ADDR;
      xfer_req.dual = 1'h0;
    end else if (state_ff == ST_FETCH) begin
      xfer_req.addr = BOOT_ADDR;
    end
  end
  srbs_flash_xfer u_xfer (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(xfer_start),
    .req(xfer_req),
    .io0_s(io0_s2_ff),
    .io1_s(io1_s2_ff),
    .busy(xfer_busy),
    .done(xfer_done),
    .rdata(xfer_rdata),
    .pins(xfer_pins)
  );
  assign flash_cs_n = xfer_pins.cs_n;
  assign flash_sclk = xfer_pins.sclk;
  assign flash_io0_o = xfer_pins.io0_o;
  assign flash_io0_oe = strap_done_ff && xfer_pins.io0_oe;
  assign flash_io0_pd_en = !strap_done_ff;
  assign boot_from_ext = boot_ext_ff;
  assign boot_ready = (state_ff == ST_RUN);

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  assign wr_fire = aw_have_ff && w_have_ff && !bvalid_ff;
  assign wr_ctl = wr_fire && (aw_addr_ff == CTRL_OFS) && w_strb_ff[0];
  assign wr_raddr = wr_fire && (aw_addr_ff == RADDR_OFS);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dual_en_ff <= CTRL_RST[CTL_DUAL_BIT];
      mode3_ff <= CTRL_RST[CTL_MODE3_BIT];
    end else if (wr_ctl) begin
      dual_en_ff <= w_data_ff[CTL_DUAL_BIT];
      mode3_ff <= w_data_ff[CTL_MODE3_BIT];
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      raddr_ff <= RADDR_RST;
    end else if (wr_raddr) begin
      for (int i = 0; i < 3; i++) begin
        if (w_strb_ff[i]) begin
          raddr_ff[8*i +: 8] <= w_data_ff[8*i +: 8];
        end
      end
    end
  end
  // Request and done flags: a new event wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_go_ff <= 1'h0;
      done_flag_ff <= 1'h0;
    end else begin
      if (wr_raddr) begin
        sw_go_ff <= 1'h1;
      end else if (sw_take) begin
        sw_go_ff <= 1'h0;
      end
      if (fetch_done) begin
        done_flag_ff <= 1'h1;
      end else if (wr_ctl && w_data_ff[CTL_DONE_BIT]) begin
        done_flag_ff <= 1'h0;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      word_ff <= '0;
    end else if (fetch_done) begin
      word_ff <= xfer_rdata;
    end
  end
  always_comb begin
    ctl_rd = '0;
    ctl_rd[CTL_DUAL_BIT] = dual_en_ff;
    ctl_rd[CTL_SPEED_BIT] = speed_ff;
    ctl_rd[CTL_MODE3_BIT] = mode3_ff;
    ctl_rd[CTL_BOOTEXT_BIT] = boot_ext_ff;
    ctl_rd[CTL_BUSY_BIT] = xfer_busy;
    ctl_rd[CTL_DONE_BIT] = done_flag_ff;
    unique case (s_axi_araddr)
      CTRL_OFS: rd_mux = {24'h000000, ctl_rd};
      RADDR_OFS: rd_mux = {8'h00, raddr_ff};
      RDATA_OFS: rd_mux = word_ff;
      default: rd_mux = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_have_ff && !bvalid_ff;
  assign s_axi_wready = !w_have_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_ff <= 1'h0;
      w_have_ff <= 1'h0;
      bvalid_ff <= 1'h0;
      aw_addr_ff <= '0;
      w_data_ff <= '0;
      w_strb_ff <= '0;
      bresp_ff <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_ff <= 1'h1;
        aw_addr_ff <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_ff <= 1'h0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_ff <= 1'h1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_ff <= 1'h0;
      end
      if (wr_fire) begin
        bvalid_ff <= 1'h1;
        bresp_ff <= reg_hit(aw_addr_ff) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'h0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'h0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= '0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'h1;
      rresp_ff <= reg_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      rdata_ff <= rd_mux;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'h0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_sig_read_req: assert property (@(posedge aclk) disable iff (!aresetn)
    state_ff == ST_SIG |-> xfer_start && xfer_req.addr == SIG_ADDR && !xfer_busy)
    else $error("signature read not issued at its address");
  a_sig_single_speed: assert property (@(posedge aclk) disable iff (!aresetn)
    state_ff == ST_SIG |-> !xfer_req.dual && xfer_req.fast == speed_ff)
    else $error("signature read not single-bit at latched speed");
  a_boot_fetch_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(boot_ext_ff) |-> xfer_start && xfer_req.addr == BOOT_ADDR ##1 xfer_busy)
    else $error("external boot did not fetch from address zero");
  a_no_sig_internal: assert property (@(posedge aclk) disable iff (!aresetn)
    state_ff == ST_SIG_WAIT && xfer_done && xfer_rdata != SIG_WORD
    |=> !boot_ext_ff && boot_ready)
    else $error("mismatch did not keep internal boot");
  a_strap_pin_hiz: assert property (@(posedge aclk)
    !aresetn |=> !flash_io0_oe && flash_io0_pd_en)
    else $error("strap pin driven or pull-down off during reset");
  a_strap_latch: assert property (@(posedge aclk) disable iff (!aresetn)
    state_ff == ST_STRAP |=> speed_ff == $past(io0_s2_ff) && !flash_io0_pd_en)
    else $error("strap level not latched at reset release");
  a_speed_readback: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && s_axi_araddr == CTRL_OFS
    |=> s_axi_rvalid && s_axi_rdata[CTL_SPEED_BIT] == speed_ff)
    else $error("control register speed field wrong");
  a_boot_fixed: assert property (@(posedge aclk) disable iff (!aresetn)
    boot_ready |=> boot_ready && $stable(boot_ext_ff))
    else $error("boot source changed after decision");

endmodule : srbs_boot_select

// ===== srbs_flash_model.sv
// Serial flash model: 4-byte reads, single and dual data, clock modes 0 and 3
module srbs_flash_model (
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic io0,
  input wire logic present,
  input wire logic sig_ok,
  output logic io1_o,
  output logic io0_o,
  output logic io0_oe
);
  import srbs_pkg::*;
  int cnt;
  logic [31:0] hdr;
  logic [31:0] word;
  logic [7:0] last_cmd;
  logic [23:0] last_addr;

  // ----------------------------------------------------------------
  // Image: signature window, filler elsewhere over a 16 MB space
  // ----------------------------------------------------------------
  function automatic logic [7:0] byte_at(input logic [23:0] a);
    if (sig_ok && a >= SIG_ADDR && a < SIG_ADDR + 24'h000004) begin
      return SIG_WORD[31 - 8 * int'(a - SIG_ADDR) -: 8];
    end
    return a[7:0] ^ 8'hA5;
  endfunction : byte_at

  initial begin
    cnt = 0;
    io1_o = 1'h0;
    io0_o = 1'h0;
    io0_oe = 1'h0;
  end

  always @(negedge cs_n) cnt = 0;

  // Released data lines fall to the pull-down level
  always @(posedge cs_n) begin
    io1_o = 1'h0;
    io0_oe = 1'h0;
  end

  // Both modes sample on the rising clock
  always @(posedge sclk) begin
    if (!cs_n && present) begin
      if (cnt < 32) hdr = {hdr[30:0], io0};
      cnt = cnt + 1;
      if (cnt == 32) begin
        last_cmd = hdr[31:24];
        last_addr = hdr[23:0];
        word = {byte_at(last_addr), byte_at(last_addr + 24'h000001),
                byte_at(last_addr + 24'h000002), byte_at(last_addr + 24'h000003)};
      end
    end
  end

  // Data change after the falling clock and stand through the high phase
  always @(negedge sclk) begin
    if (!cs_n && present && cnt >= 32) begin
      if (last_cmd == CMD_DREAD && cnt >= 40 && cnt < 56) begin
        io0_oe = 1'h1;
        io1_o = word[31 - 2 * (cnt - 40)];
        io0_o = word[30 - 2 * (cnt - 40)];
      end else if (last_cmd == CMD_READ && cnt < 64) begin
        io1_o = word[63 - cnt];
      end
    end
  end
endmodule : srbs_flash_model

// ===== srbs_flash_xfer.sv
// Serial flash read engine: one 4-byte read, single or dual data, mode 0 or 3
module srbs_flash_xfer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input srbs_pkg::srbs_xfer_req_t req,
  input wire logic io0_s,
  input wire logic io1_s,
  output logic busy,
  output logic done,
  output logic [31:0] rdata,
  output srbs_pkg::srbs_flash_out_t pins
);
  import srbs_pkg::*;

  logic busy_ff;
  logic done_ff;
  logic hi_ff;
  logic dual_ff;
  logic fast_ff;
  logic mode3_ff;
  logic [6:0] idx_ff;
  logic [3:0] half_ff;
  logic [31:0] out_ff;
  logic [31:0] in_ff;
  srbs_flash_out_t pins_ff;
  logic go;
  logic tick;
  logic rise;
  logic fall;
  logic fin;
  logic sample;
  logic [6:0] last_idx;
  logic [6:0] data_idx;
  logic [7:0] go_cmd;

  function automatic logic [7:0] cmd_of(input logic dual);
    cmd_of = dual ? CMD_DREAD : CMD_READ;
  endfunction : cmd_of

  // ----------------------------------------------------------------
  // Bit timing
  // ----------------------------------------------------------------
  assign go = !busy_ff && start;
  assign go_cmd = cmd_of(req.dual);
  assign tick = busy_ff && (half_ff == (fast_ff ? HALF_FAST_M1 : HALF_SLOW_M1));
  assign rise = tick && !hi_ff;
  assign fall = tick && hi_ff;
  assign last_idx = dual_ff ? IDX_LAST_DUAL : IDX_LAST_SINGLE;
  assign data_idx = dual_ff ? IDX_DATA_DUAL : IDX_DATA_SINGLE;
  assign sample = fall && (idx_ff >= data_idx);
  assign fin = fall && (idx_ff == last_idx);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_ff <= 1'h0;
      done_ff <= 1'h0;
      hi_ff <= 1'h0;
      idx_ff <= '0;
      half_ff <= '0;
      dual_ff <= 1'h0;
      fast_ff <= 1'h0;
      mode3_ff <= 1'h0;
    end else begin
      done_ff <= fin;
      if (go) begin
        busy_ff <= 1'h1;
        idx_ff <= '0;
        half_ff <= '0;
        hi_ff <= 1'h0;
        dual_ff <= req.dual;
        fast_ff <= req.fast;
        mode3_ff <= req.mode3;
      end else if (tick) begin
        half_ff <= '0;
        hi_ff <= !hi_ff;
        if (fall) begin
          idx_ff <= idx_ff + 7'h01;
        end
        if (fin) begin
          busy_ff <= 1'h0;
        end
      end else if (busy_ff) begin
        half_ff <= half_ff + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Shift registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_ff <= '0;
      in_ff <= '0;
    end else if (go) begin
      out_ff <= {go_cmd, req.addr};
      in_ff <= '0;
    end else if (fall) begin
      out_ff <= {out_ff[30:0], 1'h0};
      if (sample && dual_ff) begin
        in_ff <= {in_ff[29:0], io1_s, io0_s};
      end else if (sample) begin
        in_ff <= {in_ff[30:0], io1_s};
      end
    end
  end

  // ----------------------------------------------------------------
  // Pins: data launched on the falling edge, sampled before it
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins_ff <= PINS_IDLE;
    end else if (go) begin
      pins_ff <= '{cs_n: 1'h0, sclk: 1'h0, io0_o: go_cmd[7], io0_oe: 1'h1};
    end else if (rise) begin
      pins_ff.sclk <= 1'h1;
    end else if (fin) begin
      pins_ff <= '{cs_n: 1'h1, sclk: mode3_ff, io0_o: 1'h0, io0_oe: 1'h1};
    end else if (fall) begin
      pins_ff.sclk <= 1'h0;
      pins_ff.io0_o <= out_ff[30];
      pins_ff.io0_oe <= !(dual_ff && idx_ff >= IDX_CMD_LAST);
    end else if (!busy_ff) begin
      pins_ff.sclk <= req.mode3;
    end
  end

  assign busy = busy_ff;
  assign done = done_ff;
  assign rdata = in_ff;
  assign pins = pins_ff;

  a_dual_release: assert property (@(posedge aclk) disable iff (!aresetn)
    busy_ff && dual_ff && idx_ff > IDX_CMD_LAST |-> !pins_ff.io0_oe)
    else $error("io0 still driven in dual data phase");

  a_mode_idle_level: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(busy_ff) |-> pins_ff.cs_n && pins_ff.sclk == mode3_ff && $past(pins_ff.sclk))
    else $error("serial clock idle level wrong after read");

endmodule : srbs_flash_xfer

// ===== srbs_pkg.sv
// Package: constants, states and carriers for the serial flash boot selector
package srbs_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [15:0] CTRL_OFS = 16'h2400;
  localparam logic [15:0] RADDR_OFS = 16'h2404;
  localparam logic [15:0] RDATA_OFS = 16'h2408;
  localparam logic [7:0] CTRL_RST = 8'h02;
  localparam logic [23:0] RADDR_RST = 24'h000000;
  localparam int CTL_DUAL_BIT = 0;
  localparam int CTL_SPEED_BIT = 1;
  localparam int CTL_MODE3_BIT = 2;
  localparam int CTL_BOOTEXT_BIT = 3;
  localparam int CTL_BUSY_BIT = 4;
  localparam int CTL_DONE_BIT = 5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Boot image layout and flash commands
  // ----------------------------------------------------------------
  localparam logic [23:0] SIG_ADDR = 24'h00FFFA;
  localparam logic [23:0] BOOT_ADDR = 24'h000000;
  localparam logic [31:0] SIG_WORD = 32'h32444655;
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_DREAD = 8'h3B;

  // ----------------------------------------------------------------
  // Serial clock timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int SCK_FAST_HZ = 60_000_000;
  localparam int SCK_SLOW_HZ = 2_500_000;
  // Half period must cover the two-stage input synchroniser
  localparam int HALF_MIN = 3;
  localparam int HALF_FAST_RAW = (CLK_HZ + 2 * SCK_FAST_HZ - 1) / (2 * SCK_FAST_HZ);
  localparam int HALF_FAST = (HALF_FAST_RAW < HALF_MIN) ? HALF_MIN : HALF_FAST_RAW;
  localparam int HALF_SLOW_RAW = (CLK_HZ + 2 * SCK_SLOW_HZ - 1) / (2 * SCK_SLOW_HZ);
  localparam int HALF_SLOW = (HALF_SLOW_RAW < HALF_MIN) ? HALF_MIN : HALF_SLOW_RAW;
  localparam logic [3:0] HALF_FAST_M1 = 4'(HALF_FAST - 1);
  localparam logic [3:0] HALF_SLOW_M1 = 4'(HALF_SLOW - 1);

  // Serial clock indices: 8 command + 24 address, 8 dummy in dual mode
  localparam logic [6:0] IDX_CMD_LAST = 7'h1F;
  localparam logic [6:0] IDX_DATA_SINGLE = 7'h20;
  localparam logic [6:0] IDX_LAST_SINGLE = 7'h3F;
  localparam logic [6:0] IDX_DATA_DUAL = 7'h28;
  localparam logic [6:0] IDX_LAST_DUAL = 7'h37;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_STRAP,
    ST_SIG,
    ST_SIG_WAIT,
    ST_FETCH,
    ST_FWAIT,
    ST_RUN
  } srbs_boot_st_t;

  typedef struct packed {
    logic [23:0] addr;
    logic dual;
    logic fast;
    logic mode3;
  } srbs_xfer_req_t;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic io0_o;
    logic io0_oe;
  } srbs_flash_out_t;

  localparam srbs_flash_out_t PINS_IDLE = '{cs_n: 1'h1, sclk: 1'h0, io0_o: 1'h0, io0_oe: 1'h1};

endpackage : srbs_pkg
